// ===== rtl/i2c_master_slave_controller.sv
`timescale 1ns/1ps
`include "i2c_ctrl_regs.svh"
// Behaviour
// - fast or standard rate, reset leaves master disabled
// - bit divider derived from module clock rate
// - bus busy while any master holds bus
// - master busy while own engine transfers
// - single and burst commands, both directions
// - one error code reported per operation
// - data read returns last received byte
// - data write loads next transmitted byte
// - disabled master leaves bus alone
// - separate enable and clear per source
// - seven-bit address plus direction flag sent
// - target compares addresses with own address
// - target reports one action state
// - raw and masked interrupt status readable
module i2c_master_slave_controller #(
  parameter int CLK_HZ = `CLK_HZ
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  output logic irq
);
  // quarter bit lengths, rounded up so the rate never exceeds the target
  localparam int STD_Q_INT = (CLK_HZ + `QUARTERS * `RATE_STD_BPS - 1) / (`QUARTERS * `RATE_STD_BPS);
  localparam int FAST_Q_INT = (CLK_HZ + `QUARTERS * `RATE_FAST_BPS - 1) / (`QUARTERS * `RATE_FAST_BPS);
  localparam i2c_pkg::tick_t STD_Q = i2c_pkg::tick_t'(STD_Q_INT - 1);
  localparam i2c_pkg::tick_t FAST_Q = i2c_pkg::tick_t'(FAST_Q_INT - 1);

  i2c_pkg::top_state_t s;
  i2c_pkg::top_state_t next_s;
  i2c_target_if tif ();
  logic sl;
  logic dl;
  logic start_det;
  logic stop_det;
  logic tick;
  logic cmd_wr;
  logic [3:0] cmd;
  logic launch;
  logic run_byte;
  logic stop_only;
  logic done;
  logic rd_go;
  logic ackslot;
  logic rx_data;
  i2c_pkg::tick_t qlen;

  i2c_target u_target (
    .hclk(hclk),
    .hresetn(hresetn),
    .tif(tif)
  );

  assign sl = s.scl_sync[1];
  assign dl = s.sda_sync[1];
  assign start_det = sl & s.scl_prev & s.sda_prev & ~dl;
  assign stop_det = sl & s.scl_prev & ~s.sda_prev & dl;
  assign tick = (s.cnt == '0);
  assign ackslot = (s.bitcnt == `LAST_BIT);
  assign rx_data = s.rx_mode & ~s.is_addr;
  assign tif.scl = sl;
  assign tif.sda = dl;
  assign tif.start_det = start_det;
  assign tif.stop_det = stop_det;
  assign tif.enable = s.t_en;
  assign tif.own_addr = s.own;
  assign tif.tx_byte = s.t_tx;
  assign hrdata = s.hrdata;
  assign hreadyout = s.hreadyout;
  assign hresp = s.hresp;
  assign scl_oe = s.scl_oe;
  assign sda_oe = s.sda_oe;
  assign irq = s.irq;
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;

  ////////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_s = s;
    cmd = 4'h0;
    cmd_wr = 1'b0;
    launch = 1'b0;
    run_byte = 1'b0;
    stop_only = 1'b0;
    done = 1'b0;
    tif.action_clr = 1'b0;
    qlen = s.fast ? FAST_Q : STD_Q;
    next_s.scl_sync = {s.scl_sync[0], scl_in};
    next_s.sda_sync = {s.sda_sync[0], sda_in};
    next_s.scl_prev = sl;
    next_s.sda_prev = dl;
    if (start_det) begin
      next_s.bus_busy = 1'b1;
    end else if (stop_det) begin
      next_s.bus_busy = 1'b0;
    end
    // register writes in the data phase
    if (s.ph_write) begin
      case (s.ph_addr)
        `REG_MCTRL: begin
          next_s.en = hwdata[`BIT_EN];
          next_s.fast = hwdata[`BIT_FAST];
        end
        `REG_MADDR: next_s.sa = hwdata[7:0];
        `REG_MDATA: next_s.tx_byte = hwdata[7:0];
        `REG_MCMD: begin
          cmd = hwdata[3:0];
          cmd_wr = 1'b1;
        end
        `REG_TCTRL: next_s.t_en = hwdata[`BIT_EN];
        `REG_TADDR: next_s.own = hwdata[6:0];
        `REG_TDATA: begin
          next_s.t_tx = hwdata[7:0];
          tif.action_clr = 1'b1;
        end
        `REG_INT_RAW: next_s.int_raw = s.int_raw & ~hwdata[1:0];
        `REG_INT_MASK: next_s.int_mask = hwdata[1:0];
        default: begin
        end
      endcase
    end
    // master engine
    if (s.state == i2c_pkg::m_start || s.state == i2c_pkg::m_bit || s.state == i2c_pkg::m_stop) begin
      next_s.cnt = tick ? qlen : s.cnt - 1'b1;
    end
    case (s.state)
      i2c_pkg::m_idle: begin
        if (cmd_wr && s.en && cmd[`CMD_START]) begin
          if (s.bus_busy) begin
            next_s.err = i2c_pkg::err_arbitration_lost;
            done = 1'b1;
          end else begin
            launch = 1'b1;
          end
        end
      end
      i2c_pkg::m_hold: begin
        if (cmd_wr) begin
          launch = cmd[`CMD_START];
          run_byte = ~cmd[`CMD_START] & cmd[`CMD_RUN];
          stop_only = ~cmd[`CMD_START] & ~cmd[`CMD_RUN] & cmd[`CMD_STOP];
        end
      end
      i2c_pkg::m_start: begin
        if (tick) begin
          case (s.q)
            2'h0: begin
              next_s.m_sda_oe = 1'b0;
              next_s.q = 2'h1;
            end
            2'h1: begin
              next_s.scl_oe = 1'b0;
              next_s.q = sl ? 2'h2 : 2'h1;
            end
            2'h2: begin
              next_s.m_sda_oe = 1'b1;
              next_s.q = `Q_LAST;
            end
            default: begin
              next_s.scl_oe = 1'b1;
              next_s.state = i2c_pkg::m_bit;
              next_s.q = 2'h0;
              next_s.bitcnt = 4'h0;
              next_s.is_addr = 1'b1;
              next_s.sh = s.sa;
            end
          endcase
        end
      end
      i2c_pkg::m_bit: begin
        if (tick) begin
          case (s.q)
            2'h0: begin
              next_s.m_sda_oe = ackslot ? (rx_data & s.ack_out) : (~rx_data & ~s.sh[7]);
              next_s.q = 2'h1;
            end
            2'h1: begin
              next_s.scl_oe = 1'b0;
              next_s.q = 2'h2;
            end
            2'h2: begin
              next_s.q = sl ? `Q_LAST : 2'h2;
            end
            default: begin
              next_s.scl_oe = 1'b1;
              next_s.q = 2'h0;
              next_s.bitcnt = s.bitcnt + 4'h1;
              if (!ackslot) begin
                next_s.sh = {s.sh[6:0], dl};
              end
              if (!ackslot && !rx_data && s.sh[7] && !dl) begin
                next_s.state = i2c_pkg::m_idle;
                next_s.scl_oe = 1'b0;
                next_s.m_sda_oe = 1'b0;
                next_s.err = i2c_pkg::err_arbitration_lost;
                next_s.busy = 1'b0;
                done = 1'b1;
              end else if (ackslot && s.is_addr) begin
                next_s.is_addr = 1'b0;
                next_s.bitcnt = 4'h0;
                next_s.sh = s.tx_byte;
                if (dl) begin
                  next_s.err = i2c_pkg::err_address_nack;
                  next_s.state = i2c_pkg::m_stop;
                end
              end else if (ackslot) begin
                if (rx_data) begin
                  next_s.rx_byte = s.sh;
                end
                if (!rx_data && dl) begin
                  next_s.err = i2c_pkg::err_data_nack;
                  next_s.state = i2c_pkg::m_stop;
                end else if (s.stop_after) begin
                  next_s.state = i2c_pkg::m_stop;
                end else begin
                  next_s.state = i2c_pkg::m_hold;
                  next_s.m_sda_oe = 1'b0;
                  next_s.busy = 1'b0;
                  done = 1'b1;
                end
              end
            end
          endcase
        end
      end
      i2c_pkg::m_stop: begin
        if (tick) begin
          case (s.q)
            2'h0: begin
              next_s.m_sda_oe = 1'b1;
              next_s.q = 2'h1;
            end
            2'h1: begin
              next_s.scl_oe = 1'b0;
              next_s.q = sl ? 2'h2 : 2'h1;
            end
            2'h2: begin
              next_s.m_sda_oe = 1'b0;
              next_s.q = `Q_LAST;
            end
            default: begin
              next_s.state = i2c_pkg::m_idle;
              next_s.q = 2'h0;
              next_s.busy = 1'b0;
              done = 1'b1;
            end
          endcase
        end
      end
      default: next_s.state = i2c_pkg::m_idle;
    endcase
    if (launch || run_byte || stop_only) begin
      next_s.err = i2c_pkg::err_none;
      next_s.busy = 1'b1;
      next_s.cnt = qlen;
      next_s.q = 2'h0;
      next_s.stop_after = cmd[`CMD_STOP];
      next_s.ack_out = cmd[`CMD_ACK];
    end
    if (launch) begin
      next_s.state = i2c_pkg::m_start;
      next_s.rx_mode = s.sa[0];
    end
    if (run_byte) begin
      next_s.state = i2c_pkg::m_bit;
      next_s.bitcnt = 4'h0;
      next_s.is_addr = 1'b0;
      next_s.sh = s.tx_byte;
    end
    if (stop_only) begin
      next_s.state = i2c_pkg::m_stop;
    end
    if (!s.en) begin
      next_s.state = i2c_pkg::m_idle;
      next_s.scl_oe = 1'b0;
      next_s.m_sda_oe = 1'b0;
      next_s.busy = 1'b0;
    end
    // sticky events, set beats a simultaneous clear
    if (done) begin
      next_s.int_raw[`INT_MASTER] = 1'b1;
    end
    if (tif.evt) begin
      next_s.int_raw[`INT_TARGET] = 1'b1;
    end
    next_s.irq = |(next_s.int_raw & next_s.int_mask);
    next_s.sda_oe = next_s.m_sda_oe | tif.sda_oe;
    // address phase and read data
    rd_go = hsel & hready & htrans[1] & ~hwrite;
    next_s.ph_write = hsel & hready & htrans[1] & hwrite;
    next_s.ph_addr = haddr[11:0];
    next_s.hrdata = '0;
    if (rd_go) begin
      case (haddr[11:0])
        `REG_MCTRL: begin
          next_s.hrdata[`BIT_EN] = next_s.en;
          next_s.hrdata[`BIT_FAST] = next_s.fast;
        end
        `REG_MADDR: next_s.hrdata[7:0] = next_s.sa;
        `REG_MDATA: next_s.hrdata[7:0] = next_s.rx_byte;
        `REG_MSTAT: begin
          next_s.hrdata[`ST_BUSY] = next_s.busy;
          next_s.hrdata[`ST_BUS_BUSY] = next_s.bus_busy;
          next_s.hrdata[`ST_ERR +: $bits(i2c_pkg::err_t)] = next_s.err;
        end
        `REG_TCTRL: next_s.hrdata[`BIT_EN] = next_s.t_en;
        `REG_TADDR: next_s.hrdata[6:0] = next_s.own;
        `REG_TDATA: begin
          next_s.hrdata[7:0] = tif.rx_byte;
          tif.action_clr = 1'b1;
        end
        `REG_TSTAT: next_s.hrdata[$bits(i2c_pkg::action_t)-1:0] = tif.action;
        `REG_INT_RAW: next_s.hrdata[1:0] = next_s.int_raw;
        `REG_INT_MASK: next_s.hrdata[1:0] = next_s.int_mask;
        `REG_INT_MASKED: next_s.hrdata[1:0] = next_s.int_raw & next_s.int_mask;
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= '0;
      s.hreadyout <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_hold_stop;
    s.state == i2c_pkg::m_hold && stop_only && s.en;
  endsequence
  sequence s_stop_entered;
    s.state == i2c_pkg::m_stop && s.q == 2'h0 && s.busy;
  endsequence
  property p_err_stop;
    s_hold_stop |=> s_stop_entered;
  endproperty
  a_err_stop: assert property (p_err_stop) else $error("error stop did not stop");
  property p_finish;
    (s.state == i2c_pkg::m_hold && run_byte && cmd[`CMD_STOP] && s.en)
      |=> (s.state == i2c_pkg::m_bit && s.stop_after && s.bitcnt == 4'h0);
  endproperty
  a_finish: assert property (p_finish) else $error("finish did not send byte");
  property p_launch;
    (launch && s.en) |=> (s.busy && s.state == i2c_pkg::m_start && s.err == i2c_pkg::err_none);
  endproperty
  a_launch: assert property (p_launch) else $error("start command not taken");
  property p_idle_busy;
    (s.state == i2c_pkg::m_idle) |-> !s.busy;
  endproperty
  a_idle_busy: assert property (p_idle_busy) else $error("busy while idle");
  property p_arb_busy;
    (s.state == i2c_pkg::m_idle && cmd_wr && cmd[`CMD_START] && s.en && s.bus_busy)
      |=> (s.err == i2c_pkg::err_arbitration_lost && s.int_raw[`INT_MASTER]);
  endproperty
  a_arb_busy: assert property (p_arb_busy) else $error("busy bus not reported");
  property p_disable;
    !s.en |=> (s.state == i2c_pkg::m_idle && !s.scl_oe && !s.busy);
  endproperty
  a_disable: assert property (p_disable) else $error("disabled master active");
  property p_bus_busy;
    start_det |=> s.bus_busy ##1 (s.bus_busy || $past(stop_det));
  endproperty
  a_bus_busy: assert property (p_bus_busy) else $error("bus busy not set");
  property p_bus_free;
    (stop_det && !start_det) |=> !s.bus_busy;
  endproperty
  a_bus_free: assert property (p_bus_free) else $error("bus busy not cleared");
  property p_rate;
    (s.state == i2c_pkg::m_bit && tick && s.en && !cmd_wr)
      |=> (s.cnt == ($past(s.fast) ? FAST_Q : STD_Q));
  endproperty
  a_rate: assert property (p_rate) else $error("wrong quarter length");
  property p_addr_load;
    (s.state == i2c_pkg::m_start && s.q == `Q_LAST && tick && s.en)
      |=> (s.is_addr && s.sh == $past(s.sa) && s.bitcnt == 4'h0);
  endproperty
  a_addr_load: assert property (p_addr_load) else $error("address byte wrong");
  property p_rdata;
    (rd_go && haddr[11:0] == `REG_MDATA) |=> (hrdata[7:0] == s.rx_byte && hrdata[31:8] == '0);
  endproperty
  a_rdata: assert property (p_rdata) else $error("data read wrong");
  property p_wdata;
    (s.ph_write && s.ph_addr == `REG_MDATA) |=> (s.tx_byte == $past(hwdata[7:0]));
  endproperty
  a_wdata: assert property (p_wdata) else $error("data write lost");
  property p_irq;
    irq == |(s.int_raw & s.int_mask);
  endproperty
  a_irq: assert property (p_irq) else $error("irq level wrong");
  property p_int_clear;
    (s.ph_write && s.ph_addr == `REG_INT_RAW && hwdata[`INT_MASTER] && !done)
      |=> !s.int_raw[`INT_MASTER];
  endproperty
  a_int_clear: assert property (p_int_clear) else $error("master int not cleared");
endmodule // i2c_master_slave_controller

// ===== rtl/i2c_ctrl_regs.svh
`ifndef I2C_CTRL_REGS_SVH
`define I2C_CTRL_REGS_SVH
`define REG_MCTRL 12'h000
`define REG_MADDR 12'h004
`define REG_MDATA 12'h008
`define REG_MCMD 12'h00C
`define REG_MSTAT 12'h010
`define REG_TCTRL 12'h014
`define REG_TADDR 12'h018
`define REG_TDATA 12'h01C
`define REG_TSTAT 12'h020
`define REG_INT_RAW 12'h024
`define REG_INT_MASK 12'h028
`define REG_INT_MASKED 12'h02C
`define BIT_EN 0
`define BIT_FAST 1
`define ST_BUSY 0
`define ST_BUS_BUSY 1
`define ST_ERR 2
`define CMD_RUN 0
`define CMD_START 1
`define CMD_STOP 2
`define CMD_ACK 3
`define CMD_SINGLE_TX 4'h7
`define CMD_SINGLE_RX 4'h7
`define CMD_BURST_TX_START 4'h3
`define CMD_BURST_TX_CONTINUE 4'h1
`define CMD_BURST_TX_FINISH 4'h5
`define CMD_BURST_TX_ERROR_STOP 4'h4
`define CMD_BURST_RX_START 4'hB
`define CMD_BURST_RX_CONTINUE 4'h9
`define CMD_BURST_RX_FINISH 4'h5
`define CMD_BURST_RX_ERROR_STOP 4'h4
`define INT_MASTER 0
`define INT_TARGET 1
`define RATE_FAST_BPS 400000
`define RATE_STD_BPS 100000
`define CLK_HZ 250000000
`define QUARTERS 4
`define LAST_BIT 4'h8
`define LAST_TX_BIT 4'h7
`define Q_LAST 2'h3
`endif

// ===== rtl/i2c_pkg.sv
package i2c_pkg;
  typedef logic [9:0] tick_t;
  typedef enum logic [2:0] {m_idle, m_start, m_bit, m_hold, m_stop} mstate_t;
  typedef enum logic [2:0] {t_idle, t_addr, t_ack_addr, t_rx, t_ack_rx, t_tx, t_tx_ack} tstate_t;
  typedef enum logic [1:0] {
    err_none, err_address_nack, err_data_nack, err_arbitration_lost
  } err_t;
  typedef enum logic [1:0] {
    target_no_action, target_data_received, target_data_requested, target_first_byte_received
  } action_t;
  typedef struct packed {
    logic [1:0] scl_sync;
    logic [1:0] sda_sync;
    logic scl_prev;
    logic sda_prev;
    logic bus_busy;
    logic ph_write;
    logic [11:0] ph_addr;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic irq;
    logic sda_oe;
    logic en;
    logic fast;
    logic [7:0] sa;
    logic [7:0] tx_byte;
    logic [7:0] rx_byte;
    err_t err;
    logic t_en;
    logic [6:0] own;
    logic [7:0] t_tx;
    logic [1:0] int_raw;
    logic [1:0] int_mask;
    mstate_t state;
    logic [1:0] q;
    tick_t cnt;
    logic [3:0] bitcnt;
    logic [7:0] sh;
    logic is_addr;
    logic rx_mode;
    logic stop_after;
    logic ack_out;
    logic scl_oe;
    logic m_sda_oe;
    logic busy;
  } top_state_t;
  typedef struct packed {
    tstate_t state;
    logic scl_prev;
    logic [7:0] sh;
    logic [3:0] cnt;
    logic rw;
    logic first;
    logic acked;
    logic sda_oe;
    logic [7:0] rx_byte;
    action_t action;
    logic evt;
  } target_state_t;
endpackage

// ===== rtl/i2c_target_if.sv
`timescale 1ns/1ps
interface i2c_target_if;
  logic scl;
  logic sda;
  logic start_det;
  logic stop_det;
  logic enable;
  logic [6:0] own_addr;
  logic [7:0] tx_byte;
  logic action_clr;
  logic sda_oe;
  logic [7:0] rx_byte;
  i2c_pkg::action_t action;
  logic evt;
  modport ctrl (output scl, sda, start_det, stop_det, enable, own_addr, tx_byte, action_clr,
    input sda_oe, rx_byte, action, evt);
  modport target (input scl, sda, start_det, stop_det, enable, own_addr, tx_byte, action_clr,
    output sda_oe, rx_byte, action, evt);
endinterface

// ===== rtl/i2c_target.sv
`timescale 1ns/1ps
`include "i2c_ctrl_regs.svh"
module i2c_target (
  input wire logic hclk,
  input wire logic hresetn,
  i2c_target_if.target tif
);
  i2c_pkg::target_state_t s;
  i2c_pkg::target_state_t next_s;
  logic rise;
  logic fall;
  assign rise = tif.scl & ~s.scl_prev;
  assign fall = ~tif.scl & s.scl_prev;
  assign tif.sda_oe = s.sda_oe;
  assign tif.rx_byte = s.rx_byte;
  assign tif.action = s.action;
  assign tif.evt = s.evt;

  always_comb begin
    next_s = s;
    next_s.evt = 1'b0;
    next_s.scl_prev = tif.scl;
    if (tif.action_clr) begin
      next_s.action = i2c_pkg::target_no_action;
    end
    case (s.state)
      i2c_pkg::t_addr, i2c_pkg::t_rx: begin
        if (rise) begin
          next_s.sh = {s.sh[6:0], tif.sda};
          next_s.cnt = s.cnt + 4'h1;
        end else if (fall && s.cnt == `LAST_BIT) begin
          if (s.state == i2c_pkg::t_rx) begin
            next_s.sda_oe = 1'b1;
            next_s.rx_byte = s.sh;
            next_s.action = s.first ? i2c_pkg::target_first_byte_received :
                            i2c_pkg::target_data_received;
            next_s.first = 1'b0;
            next_s.evt = 1'b1;
            next_s.state = i2c_pkg::t_ack_rx;
          end else if (s.sh[7:1] == tif.own_addr) begin
            next_s.sda_oe = 1'b1;
            next_s.rw = s.sh[0];
            next_s.state = i2c_pkg::t_ack_addr;
          end else begin
            next_s.state = i2c_pkg::t_idle;
          end
        end
      end
      i2c_pkg::t_ack_addr, i2c_pkg::t_ack_rx: begin
        if (fall) begin
          next_s.sda_oe = 1'b0;
          next_s.cnt = 4'h0;
          next_s.state = i2c_pkg::t_rx;
          if (s.state == i2c_pkg::t_ack_addr && s.rw) begin
            next_s.state = i2c_pkg::t_tx;
            next_s.sh = tif.tx_byte;
            next_s.sda_oe = ~tif.tx_byte[7];
            next_s.action = i2c_pkg::target_data_requested;
            next_s.evt = 1'b1;
          end
        end
      end
      i2c_pkg::t_tx: begin
        if (fall) begin
          if (s.cnt == `LAST_TX_BIT) begin
            next_s.sda_oe = 1'b0;
            next_s.state = i2c_pkg::t_tx_ack;
          end else begin
            next_s.sh = {s.sh[6:0], 1'b0};
            next_s.sda_oe = ~s.sh[6];
            next_s.cnt = s.cnt + 4'h1;
          end
        end
      end
      i2c_pkg::t_tx_ack: begin
        if (rise) begin
          next_s.acked = ~tif.sda;
        end else if (fall) begin
          next_s.state = s.acked ? i2c_pkg::t_tx : i2c_pkg::t_idle;
          next_s.cnt = 4'h0;
          next_s.sh = tif.tx_byte;
          next_s.sda_oe = s.acked & ~tif.tx_byte[7];
          if (s.acked) begin
            next_s.action = i2c_pkg::target_data_requested;
            next_s.evt = 1'b1;
          end
        end
      end
      default: begin
      end
    endcase
    if (tif.stop_det || !tif.enable) begin
      next_s.state = i2c_pkg::t_idle;
      next_s.sda_oe = 1'b0;
    end else if (tif.start_det) begin
      next_s.state = i2c_pkg::t_addr;
      next_s.cnt = 4'h0;
      next_s.first = 1'b1;
      next_s.sda_oe = 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  property p_addr_mismatch;
    (s.state == i2c_pkg::t_addr && fall && s.cnt == `LAST_BIT && s.sh[7:1] != tif.own_addr
     && !tif.start_det) |=> (!s.sda_oe && s.state == i2c_pkg::t_idle);
  endproperty
  a_addr_mismatch: assert property (p_addr_mismatch) else $error("unmatched address acked");
  property p_first_byte;
    (s.state == i2c_pkg::t_rx && fall && s.cnt == `LAST_BIT && s.first && tif.enable
     && !tif.stop_det && !tif.start_det)
      |=> (s.action == i2c_pkg::target_first_byte_received && s.evt && s.sda_oe);
  endproperty
  a_first_byte: assert property (p_first_byte) else $error("first byte action missing");
endmodule // i2c_target

// ===== bench/i2c_dev_model.sv
`timescale 1ns/1ps
module i2c_dev_model #(
  parameter logic [6:0] ADDR = 7'h2D,
  parameter logic [7:0] RD = 8'hA5
) (
  input wire logic scl,
  input wire logic sda,
  output logic pull,
  output logic [7:0] got
);
  logic [7:0] sh;
  initial pull = 1'b0;
  initial got = 8'h00;
  // far device: ack own address, take or give one byte
  always begin
    @(negedge sda iff scl === 1'b1);
    repeat (8) @(posedge scl) sh = {sh[6:0], sda};
    @(negedge scl);
    if (sh[7:1] == ADDR) begin
      pull = 1'b1;
      @(negedge scl);
      for (int i = 7; i >= 0; i--) begin
        pull = sh[0] ? !RD[i] : 1'b0;
        if (!sh[0]) @(posedge scl) got = {got[6:0], sda};
        @(negedge scl);
      end
      pull = !sh[0];
      if (!sh[0]) @(negedge scl);
      pull = 1'b0;
    end
  end
endmodule // i2c_dev_model

// ===== bench/i2c_master_slave_controller_tb.sv
`timescale 1ns/1ps
`include "i2c_ctrl_regs.svh"
module i2c_master_slave_controller_tb;
  logic hclk, hresetn, hsel, hwrite, hready, hresp, irq, scl_oe, sda_oe, pull, scl, sda;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic [7:0] got;
  int fails = 0;
  int num_checks = 0;
  assign scl = !scl_oe;
  assign sda = !(sda_oe | pull);
  i2c_master_slave_controller u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hready), .hresp(hresp), .scl_in(scl),
    .scl_out(), .scl_oe(scl_oe), .sda_in(sda), .sda_out(), .sda_oe(sda_oe), .irq(irq));
  i2c_dev_model u_dev (.scl(scl), .sda(sda), .pull(pull), .got(got));
  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      fails++;
      $display("unexpected at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic ahb(input logic w, input logic [11:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {20'h0, a};
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    r = hrdata;
  endtask
  task automatic run(input logic [7:0] a, input logic [3:0] c, input logic [3:0] e);
    logic seen;
    seen = 1'b0;
    ahb(1'b1, `REG_MADDR, {24'h0, a});
    ahb(1'b1, `REG_MCMD, {28'h0, c});
    ahb(1'b0, `REG_MSTAT, 32'h0);
    chk(r[0], 32'h1);
    for (int i = 0; i < 20000 && r[0] === 1'b1; i++) begin
      ahb(1'b0, `REG_MSTAT, 32'h0);
      seen = seen | r[1];
    end
    chk(seen, 32'h1);
    chk(r[3:0], e);
  endtask
  task automatic t_reset();
    ahb(1'b0, `REG_MCTRL, 32'h0);
    chk(r, 32'h0);
    ahb(1'b0, 12'hFFC, 32'h0);
    chk(r, 32'h0);
    chk({irq, hresp}, 32'h0);
  endtask
  task automatic t_tx();
    ahb(1'b1, `REG_MCTRL, 32'h3);
    ahb(1'b0, `REG_MCTRL, 32'h0);
    chk(r, 32'h3);
    ahb(1'b1, `REG_INT_MASK, 32'h1);
    ahb(1'b1, `REG_MDATA, 32'h5C);
    run(8'h5A, `CMD_SINGLE_TX, 4'h0);
    chk(got, 32'h5C);
    chk(irq, 32'h1);
    ahb(1'b0, `REG_INT_MASKED, 32'h0);
    chk(r, 32'h1);
    ahb(1'b1, `REG_INT_RAW, 32'h1);
    ahb(1'b0, `REG_INT_RAW, 32'h0);
    chk(r, 32'h0);
    chk(irq, 32'h0);
  endtask
  task automatic t_rx();
    ahb(1'b1, `REG_INT_MASK, 32'h0);
    run(8'h5B, `CMD_SINGLE_RX, 4'h0);
    ahb(1'b0, `REG_MDATA, 32'h0);
    chk(r, 32'hA5);
    ahb(1'b0, `REG_INT_RAW, 32'h0);
    chk({r[1:0], irq}, 32'h2);
    ahb(1'b1, `REG_INT_RAW, 32'h1);
  endtask
  task automatic t_burst();
    ahb(1'b1, `REG_MDATA, 32'h96);
    run(8'h5A, `CMD_BURST_TX_START, 4'h2);
    chk(got, 32'h96);
    run(8'h5A, `CMD_BURST_TX_ERROR_STOP, 4'h0);
    run(8'h5A, `CMD_BURST_TX_START, 4'h2);
    run(8'h5A, `CMD_BURST_TX_FINISH, 4'h8);
  endtask
  task automatic t_tgt();
    ahb(1'b1, `REG_TADDR, 32'h33);
    ahb(1'b1, `REG_TCTRL, 32'h1);
    ahb(1'b1, `REG_MDATA, 32'h3C);
    run(8'h66, `CMD_SINGLE_TX, 4'h0);
    ahb(1'b0, `REG_TSTAT, 32'h0);
    chk(r, 32'h3);
    ahb(1'b0, `REG_TDATA, 32'h0);
    chk(r, 32'h3C);
    ahb(1'b0, `REG_TSTAT, 32'h0);
    chk(r, 32'h0);
    ahb(1'b0, `REG_INT_RAW, 32'h0);
    chk(r, 32'h3);
    ahb(1'b1, `REG_INT_RAW, 32'h3);
  endtask
  task automatic t_off();
    run(8'h58, `CMD_SINGLE_TX, 4'h4);
    ahb(1'b1, `REG_MCTRL, 32'h0);
    ahb(1'b1, `REG_MCMD, {28'h0, `CMD_SINGLE_TX});
    ahb(1'b0, `REG_MSTAT, 32'h0);
    chk(r, 32'h4);
    chk({scl_oe, sda_oe}, 32'h0);
  endtask
  task automatic test_done();
    if (fails == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    {hsel, hwrite, htrans, haddr, hwdata} = '0;
    hsize = 3'h2;
    hresetn = 1'b0;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_tx();
    t_rx();
    t_burst();
    t_tgt();
    t_off();
    test_done();
  end
  initial begin
    #380000;
    fails++;
    test_done();
  end
endmodule // i2c_master_slave_controller_tb
